// file: logic/qrotc_pkg.sv
// qrotc_pkg: register map, field layout, reset values and timing constants
// for the dual-rail quick-response and on-time control block.
// assumes an 8-bit register port with one-cycle read latency.
package qrotc_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_ONTIME_COEFF_A     = 8'h27;
  localparam logic [7:0] OFS_LIFT_A             = 8'h28;
  localparam logic [7:0] OFS_THRESH_MULTI_A     = 8'h2A;
  localparam logic [7:0] OFS_THRESH_SINGLE_A    = 8'h2B;
  localparam logic [7:0] OFS_TYPE_A             = 8'h30;
  localparam logic [7:0] OFS_ONTIME_COEFF_B     = 8'h67;
  localparam logic [7:0] OFS_LIFT_B             = 8'h68;
  localparam logic [7:0] OFS_THRESH_MULTI_B     = 8'h6A;
  localparam logic [7:0] OFS_THRESH_SINGLE_B    = 8'h6B;
  localparam logic [7:0] OFS_TYPE_B             = 8'h70;
  localparam logic [7:0] OFS_TRIGGER_B          = 8'h72;
  localparam logic [7:0] OFS_STATUS             = 8'h7E;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int TYPE_MULTI_BIT   = 5;
  localparam int TYPE_SINGLE_BIT  = 4;
  localparam int TRIG_SEL_BIT     = 6;
  localparam int WIDTH_B_LSB      = 5;
  localparam int WIDTH_A_LSB      = 5;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ---------------------------------------------------------------
  // on-time arithmetic, coefficient in tenths, voltages in mV
  // ---------------------------------------------------------------
  localparam logic [4:0] COEFF_BASE_LO  = 5'h03;  // 0.3
  localparam logic [4:0] COEFF_BASE_HI  = 5'h0C;  // 1.2
  localparam logic [15:0] TARGET_FLOOR_MV = 16'h0384; // 0.9 V
  localparam int ONTIME_BASE_NS   = 2000;         // 2 us
  localparam int CLK_PERIOD_NS    = 100;
  // ns per cycle -> 2 us * 10 tenths / 100 ns, rounded down for a shortest time
  localparam int ONTIME_SCALE = (ONTIME_BASE_NS * 10) / CLK_PERIOD_NS;
  // fixed response widths in cycles per width code step
  localparam int FIXED_WIDTH_STEP_NS = 100;
  localparam int FIXED_WIDTH_STEP_CYC =
    (FIXED_WIDTH_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // per-rail pulse and status carrier
  typedef struct packed {
    logic       forced_on;
    logic       abs_active;
    logic       diff_active;
    logic       lift_active;
    logic [4:0] lift_level;
  } qrotc_rail_status_t;

endpackage

// file: logic/qrotc_top.sv
// qrotc_top: per-rail configuration registers, on-time pulse length and
// fast response triggering for two rails of a multiphase buck controller.
// assumes comparator outputs and measurements synchronous to clk.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module qrotc_top #(
  parameter int PHASES_A = 8,
  parameter int PHASES_B = 2
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // register port
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [7:0]           reg_rdata,
  // rail A sense side
  input  wire logic                 voltage_transition_a,
  input  wire logic                 single_phase_a,
  input  wire logic [4:0]           falling_slew_a,
  input  wire logic [15:0]          target_mv_a,
  input  wire logic [15:0]          vin_mv_a,
  input  wire logic [7:0]           load_step_width_a,
  // rail B sense side
  input  wire logic                 voltage_transition_b,
  input  wire logic                 single_phase_b,
  input  wire logic [4:0]           falling_slew_b,
  input  wire logic [15:0]          target_mv_b,
  input  wire logic [15:0]          vin_mv_b,
  input  wire logic [7:0]           load_step_width_b,
  input  wire logic                 zero_droop_enable_b,
  input  wire logic                 output_below_abs_b,
  // outputs
  output logic      [2:0]           absolute_drop_threshold,
  output qrotc_pkg::qrotc_rail_status_t status_a,
  output qrotc_pkg::qrotc_rail_status_t status_b,
  output logic      [PHASES_A-1:0]  force_pulse_a,
  output logic      [PHASES_B-1:0]  force_pulse_b,
  output logic      [15:0]          ontime_cycles_a,
  output logic      [15:0]          ontime_cycles_b
);

  // refuse phase counts that the force vectors cannot carry
  if (PHASES_A < 1 || PHASES_A > 16 || PHASES_B < 1 || PHASES_B > 16)
  begin : g_bad_phases
    $error("phase counts must be 1..16");
  end

  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  localparam int NREG = 11;
  localparam logic [7:0] OFS [NREG] = '{
    qrotc_pkg::OFS_ONTIME_COEFF_A, qrotc_pkg::OFS_LIFT_A,
    qrotc_pkg::OFS_THRESH_MULTI_A, qrotc_pkg::OFS_THRESH_SINGLE_A,
    qrotc_pkg::OFS_TYPE_A, qrotc_pkg::OFS_ONTIME_COEFF_B,
    qrotc_pkg::OFS_LIFT_B, qrotc_pkg::OFS_THRESH_MULTI_B,
    qrotc_pkg::OFS_THRESH_SINGLE_B, qrotc_pkg::OFS_TYPE_B,
    qrotc_pkg::OFS_TRIGGER_B};

  logic [7:0]      cfg_reg [NREG];
  logic [NREG-1:0] hit;
  logic [7:0]      rd_mux;
  logic [7:0]      status_byte;

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      assign hit[gi] = (reg_addr == OFS[gi]);
      always_ff @(posedge clk) begin
        if (rst) begin
          cfg_reg[gi] <= qrotc_pkg::REG_RESET;
        end else if (reg_wr && hit[gi]) begin
          cfg_reg[gi] <= reg_wdata;
        end
      end
    end
  endgenerate

  always_comb begin
    rd_mux = qrotc_pkg::UNMAPPED_READ;
    for (int i = 0; i < NREG; i++) begin
      if (hit[i]) begin
        rd_mux = cfg_reg[i];
      end
    end
    if (reg_addr == qrotc_pkg::OFS_STATUS) begin
      rd_mux = status_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // -------------------------------------------------------------
  // field decode
  // -------------------------------------------------------------
  wire [4:0] coeff_a   = cfg_reg[0][4:0];
  wire [4:0] coeff_b   = cfg_reg[5][4:0];
  wire [4:0] lift_a    = cfg_reg[1][4:0];
  wire [4:0] lift_b    = cfg_reg[6][4:0];
  wire       trig_diff = cfg_reg[10][qrotc_pkg::TRIG_SEL_BIT];
  wire [2:0] abs_th    = cfg_reg[10][2:0];
  wire [2:0] width_b   = cfg_reg[7][qrotc_pkg::WIDTH_B_LSB +: 3];
  // threshold and type choice by phase count
  wire [4:0] th_a = single_phase_a ? cfg_reg[3][4:0]
                                   : cfg_reg[2][4:0];
  wire [4:0] th_b = single_phase_b ? cfg_reg[8][4:0]
                                   : cfg_reg[7][4:0];
  wire adapt_a = single_phase_a ? cfg_reg[4][qrotc_pkg::TYPE_SINGLE_BIT]
                                : cfg_reg[4][qrotc_pkg::TYPE_MULTI_BIT];
  wire adapt_b = single_phase_b ? cfg_reg[9][qrotc_pkg::TYPE_SINGLE_BIT]
                                : cfg_reg[9][qrotc_pkg::TYPE_MULTI_BIT];
  wire [1:0] width_a = single_phase_a
    ? cfg_reg[3][qrotc_pkg::WIDTH_A_LSB +: 2]
    : cfg_reg[2][qrotc_pkg::WIDTH_A_LSB +: 2];

  // -------------------------------------------------------------
  // on-time arithmetic
  // -------------------------------------------------------------
  function automatic logic [15:0] ontime_calc(
    input logic [4:0]  coeff,
    input logic [15:0] target,
    input logic [15:0] vin
  );
    logic [4:0]  k_tenths;
    logic [15:0] vt;
    logic [31:0] num;
    logic [31:0] den;
    logic [31:0] q;
    k_tenths = (coeff[4] ? qrotc_pkg::COEFF_BASE_HI
                         : qrotc_pkg::COEFF_BASE_LO)
               + {1'b0, coeff[3:0]};
    vt = (target > qrotc_pkg::TARGET_FLOOR_MV)
         ? target : qrotc_pkg::TARGET_FLOOR_MV;
    num = vt * 32'(qrotc_pkg::ONTIME_SCALE);
    den = {27'h0, k_tenths} * {16'h0, vin};
    q = (den == 32'h0) ? 32'h0 : num / den;
    if (q == 32'h0) begin
      q = 32'h1;
    end
    ontime_calc = (q > 32'h0000FFFF) ? 16'hFFFF : q[15:0];
  endfunction

  always_ff @(posedge clk) begin
    if (rst) begin
      ontime_cycles_a <= 16'h0000;
      ontime_cycles_b <= 16'h0000;
    end else begin
      ontime_cycles_a <= ontime_calc(coeff_a, target_mv_a, vin_mv_a);
      ontime_cycles_b <= ontime_calc(coeff_b, target_mv_b, vin_mv_b);
    end
  end

  // -------------------------------------------------------------
  // trigger logic
  // -------------------------------------------------------------
  // absolute path: rail B only and only with zero droop
  wire abs_sel_b  = !trig_diff && zero_droop_enable_b;
  wire abs_trig_b = abs_sel_b && output_below_abs_b;
  wire diff_trig_a = falling_slew_a > th_a;
  wire diff_trig_b = trig_diff && (falling_slew_b > th_b);

  // width held after the trigger drops, in cycles
  wire [7:0] fixed_len_a = 8'((width_a + 2'h1) *
                              qrotc_pkg::FIXED_WIDTH_STEP_CYC);
  wire [7:0] fixed_len_b = 8'((width_b + 3'h1) *
                              qrotc_pkg::FIXED_WIDTH_STEP_CYC);
  wire [7:0] len_a = adapt_a ? load_step_width_a : fixed_len_a;
  wire [7:0] len_b = (adapt_b && trig_diff)
                     ? load_step_width_b : fixed_len_b;

  logic [7:0] hold_a_reg;
  logic [7:0] hold_b_reg;
  wire trig_a = diff_trig_a;
  wire trig_b = abs_trig_b || diff_trig_b;

  always_ff @(posedge clk) begin
    if (rst) begin
      hold_a_reg <= 8'h00;
      hold_b_reg <= 8'h00;
    end else begin
      hold_a_reg <= trig_a ? len_a
                  : (hold_a_reg != 8'h00 ? hold_a_reg - 8'h01 : 8'h00);
      hold_b_reg <= trig_b ? len_b
                  : (hold_b_reg != 8'h00 ? hold_b_reg - 8'h01 : 8'h00);
    end
  end

  // each rail forces only its own phases
  wire force_a = trig_a || (hold_a_reg != 8'h00);
  wire force_b = trig_b || (hold_b_reg != 8'h00);

  always_ff @(posedge clk) begin
    if (rst) begin
      force_pulse_a <= '0;
      force_pulse_b <= '0;
      status_a      <= '0;
      status_b      <= '0;
      absolute_drop_threshold <= 3'h0;
    end else begin
      force_pulse_a <= {PHASES_A{force_a}};
      force_pulse_b <= {PHASES_B{force_b}};
      absolute_drop_threshold <= abs_th;
      status_a <= '{force_a, 1'b0, diff_trig_a,
                    voltage_transition_a,
                    voltage_transition_a ? lift_a : 5'h00};
      status_b <= '{force_b, abs_trig_b, diff_trig_b,
                    voltage_transition_b,
                    voltage_transition_b ? lift_b : 5'h00};
    end
  end

  assign status_byte = {4'h0, status_b.forced_on, status_b.abs_active,
                        status_a.forced_on, status_a.diff_active};

endmodule

// file: verification/qrotc_far_model.sv
// qrotc_far_model: power stages and output sense network beside the block
// assumes the bench commands load steps; sense paths lag one clock
`timescale 1ns/1ps
module qrotc_far_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // load step commands from the bench
  input  wire logic [4:0] step_a,
  input  wire logic [4:0] step_b,
  input  wire logic       sag_b,
  // sensed output behaviour
  output logic      [4:0] falling_slew_a,
  output logic      [4:0] falling_slew_b,
  output logic            output_below_abs_b
);
  // a settled output shows no falling slew, so nothing triggers falsely
  always_ff @(posedge clk) begin
    if (rst) begin
      falling_slew_a     <= 5'h00;
      falling_slew_b     <= 5'h00;
      output_below_abs_b <= 1'b0;
    end else begin
      falling_slew_a     <= step_a;
      falling_slew_b     <= step_b;
      output_below_abs_b <= sag_b;
    end
  end
endmodule

// file: verification/qrotc_props.sv
// qrotc_props: port-level checks of register reads and pulse forcing
// assumes one clock and synchronous active-high reset; bound into qrotc_top
`timescale 1ns/1ps
module qrotc_props #(
  parameter int PHASES_A = 8,
  parameter int PHASES_B = 2
) (
  input wire logic                          clk,
  input wire logic                          rst,
  input wire logic [7:0]                    reg_addr,
  input wire logic [7:0]                    reg_wdata,
  input wire logic                          reg_wr,
  input wire logic                          reg_rd,
  input wire logic [7:0]                    reg_rdata,
  input wire logic                          voltage_transition_a,
  input wire logic                          single_phase_a,
  input wire logic [4:0]                    falling_slew_a,
  input wire logic [4:0]                    falling_slew_b,
  input wire logic                          zero_droop_enable_b,
  input wire logic                          output_below_abs_b,
  input wire qrotc_pkg::qrotc_rail_status_t status_a,
  input wire logic [PHASES_A-1:0]           force_pulse_a,
  input wire logic [PHASES_B-1:0]           force_pulse_b
);
  logic       sel_b;
  logic [4:0] th_a;
  // mirror of the settings that the trigger checks depend on
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_b <= 1'b0;
      th_a  <= 5'h00;
    end else if (reg_wr) begin
      if (reg_addr == 8'h72) sel_b <= reg_wdata[6];
      if (reg_addr == 8'h2A) th_a <= reg_wdata[4:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_slew_a; !single_phase_a && falling_slew_a > th_a; endsequence
  sequence s_sag_b; !sel_b && zero_droop_enable_b && output_below_abs_b;
  endsequence
  property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");
  property p_rd_sel; reg_rd && reg_addr == 8'h72 |=> reg_rdata[6] == sel_b;
  endproperty
  a_rd_sel: assert property (p_rd_sel)
    else $error("trigger select read back wrong");
  property p_all_a; force_pulse_a == '0 || &force_pulse_a; endproperty
  a_all_a: assert property (p_all_a)
    else $error("rail a phases forced partly");
  property p_rise_a; $rose(force_pulse_a[0]) |-> $past(falling_slew_a) != 0;
  endproperty
  a_rise_a: assert property (p_rise_a)
    else $error("rail a forced without slew");
  property p_rise_b; $rose(force_pulse_b[0]) |-> $past(falling_slew_b != 0
    || (output_below_abs_b && zero_droop_enable_b)); endproperty
  a_rise_b: assert property (p_rise_b)
    else $error("rail b forced without cause");
  property p_diff_a; s_slew_a |=> &force_pulse_a; endproperty
  a_diff_a: assert property (p_diff_a)
    else $error("rail a slew trigger missed");
  property p_abs_b; s_sag_b |=> &force_pulse_b; endproperty
  a_abs_b: assert property (p_abs_b)
    else $error("rail b absolute trigger missed");
  property p_lift;
    1'b1 |=> status_a.lift_active == $past(voltage_transition_a);
  endproperty
  a_lift: assert property (p_lift)
    else $error("lift current not following transition");
endmodule

bind qrotc_top qrotc_props #(.PHASES_A(PHASES_A), .PHASES_B(PHASES_B)) u_props (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .voltage_transition_a(voltage_transition_a),
  .single_phase_a(single_phase_a), .falling_slew_a(falling_slew_a),
  .falling_slew_b(falling_slew_b), .zero_droop_enable_b(zero_droop_enable_b),
  .output_below_abs_b(output_below_abs_b), .status_a(status_a),
  .force_pulse_a(force_pulse_a), .force_pulse_b(force_pulse_b));

// file: verification/tb.sv
// tb: register, on-time and fast response scenarios for qrotc_top
// assumes the far side model and the bound checker are compiled alongside
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        sag_b = 1'b0, trans_a = 1'b0, single_a = 1'b0, zdrp = 1'b0;
  logic        trans_b = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, step_w = 8'h04;
  logic [4:0]  step_a = 5'h00, step_b = 5'h00;
  logic [15:0] tgt = 16'h0708, vin = 16'h2EE0;
  logic [7:0]  bus_rdata, force_a;
  logic [4:0]  slew_a, slew_b;
  logic [2:0]  abs_th;
  logic [1:0]  force_b;
  logic        below_b;
  logic [15:0] ont_a, ont_b;
  qrotc_pkg::qrotc_rail_status_t st_a, st_b;
  int          err_total = 0, num_checks = 0, la, lb;
  logic [7:0]  ofs [11] = '{8'h27, 8'h28, 8'h2A, 8'h2B, 8'h30, 8'h67,
                            8'h68, 8'h6A, 8'h6B, 8'h70, 8'h72};
  initial forever #50 clk = ~clk;
  qrotc_top u_dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(bus_rdata),
    .voltage_transition_a(trans_a), .single_phase_a(single_a),
    .falling_slew_a(slew_a), .target_mv_a(tgt), .vin_mv_a(vin),
    .load_step_width_a(step_w), .voltage_transition_b(trans_b),
    .single_phase_b(1'b0), .falling_slew_b(slew_b), .target_mv_b(tgt),
    .vin_mv_b(vin), .load_step_width_b(step_w), .zero_droop_enable_b(zdrp),
    .output_below_abs_b(below_b), .absolute_drop_threshold(abs_th),
    .status_a(st_a), .status_b(st_b), .force_pulse_a(force_a),
    .force_pulse_b(force_b), .ontime_cycles_a(ont_a), .ontime_cycles_b(ont_b));
  qrotc_far_model u_far (.clk(clk), .rst(rst), .step_a(step_a),
    .step_b(step_b), .sag_b(sag_b), .falling_slew_a(slew_a),
    .falling_slew_b(slew_b), .output_below_abs_b(below_b));
  task automatic chk(input string what, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [7:0] a, exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(what, 16'(bus_rdata), 16'(exp));
  endtask
  // holds a load step for n of 24 cycles, counting forced cycles per rail over all 24
  task automatic burst(input int n, input logic [4:0] sa, sb, input logic sg);
    la = 0;
    lb = 0;
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      step_a <= (i < n) ? sa : 5'h00;
      step_b <= (i < n) ? sb : 5'h00;
      sag_b  <= (i < n) && sg;
      #1 la += int'(force_a != 8'h00);
      lb += int'(force_b != 2'h0);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    foreach (ofs[i]) begin
      rchk("reset value", ofs[i], 8'h00);
      wr(ofs[i], 8'hA0 ^ ofs[i]);
      rchk("read back", ofs[i], 8'hA0 ^ ofs[i]);
      wr(ofs[i], 8'h00);
    end
    wr(8'h50, 8'hFF);
    rchk("unmapped", 8'h50, 8'h00);
    wr(8'h28, 8'h13);
    wr(8'h68, 8'h0B);
    trans_a <= 1'b1;
    trans_b <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("lift level", 16'(st_a.lift_level), 16'h0013);
    chk("lift level b", 16'(st_b.lift_level), 16'h000B);
    chk("lift active b", 16'(st_b.lift_active), 16'h0001);
    @(posedge clk);
    trans_a <= 1'b0;
    trans_b <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("lift off a", 16'(st_a.lift_level), 16'h0000);
    chk("lift off b", 16'(st_b.lift_level), 16'h0000);
    rchk("status idle", 8'h7E, 8'h00);
    wr(8'h27, 8'h10);
    wr(8'h67, 8'h05);
    repeat (4) @(posedge clk);
    #1 chk("ontime a", ont_a, 16'h0002);
    chk("ontime b", ont_b, 16'h0003);
    @(posedge clk) tgt <= 16'h0258;
    wr(8'h27, 8'h00);
    repeat (4) @(posedge clk);
    #1 chk("ontime floor a", ont_a, 16'h0005);
    chk("ontime floor b", ont_b, 16'h0001);
    for (int w = 0; w < 4; w++) begin
      wr(8'h2A, 8'(w * 32 + 5));
      burst(3, 5'h0A, 5'h00, 1'b0);
      chk("fixed width a", 16'(la), 16'(w + 4));
      chk("rail b quiet", 16'(lb), 16'h0000);
    end
    single_a <= 1'b1;
    wr(8'h2B, 8'h28);
    burst(2, 5'h06, 5'h00, 1'b0);
    chk("single below", 16'(la), 16'h0000);
    burst(2, 5'h09, 5'h00, 1'b0);
    chk("single fixed", 16'(la), 16'h0004);
    wr(8'h30, 8'h10);
    burst(2, 5'h09, 5'h00, 1'b0);
    chk("single adaptive", 16'(la), 16'h0006);
    single_a <= 1'b0;
    wr(8'h30, 8'h20);
    burst(3, 5'h0A, 5'h00, 1'b0);
    chk("multi adaptive", 16'(la), 16'h0007);
    zdrp <= 1'b1;
    wr(8'h6A, 8'h47);
    wr(8'h72, 8'h03);
    burst(2, 5'h00, 5'h00, 1'b1);
    chk("abs width b", 16'(lb), 16'h0005);
    chk("rail a quiet", 16'(la), 16'h0000);
    chk("abs threshold", 16'(abs_th), 16'h0003);
    burst(2, 5'h00, 5'h0A, 1'b0);
    chk("slew with abs", 16'(lb), 16'h0000);
    zdrp <= 1'b0;
    burst(2, 5'h00, 5'h00, 1'b1);
    chk("abs with droop", 16'(lb), 16'h0000);
    zdrp <= 1'b1;
    wr(8'h72, 8'h43);
    burst(2, 5'h00, 5'h00, 1'b1);
    chk("abs with diff", 16'(lb), 16'h0000);
    burst(2, 5'h00, 5'h0A, 1'b0);
    chk("diff width b", 16'(lb), 16'h0005);
    wr(8'h70, 8'h20);
    burst(2, 5'h00, 5'h0A, 1'b0);
    chk("adaptive b", 16'(lb), 16'h0006);
    close_out();
  end
endmodule
